/* File: core/utopia_rx_enable_cfg.svh */
// Offsets, field positions, reset values and counts of the receive enable registers
`ifndef UTOPIA_RX_ENABLE_CFG_SVH
`define UTOPIA_RX_ENABLE_CFG_SVH

// Register offsets on the 10-bit processor address
`define OFS_LINK_ADDR_BASE 10'h040
`define OFS_GROUP_ADDR_BASE 10'h048
`define OFS_LINK_ENABLE 10'h04c
`define OFS_GROUP_ENABLE 10'h04d
`define OFS_TX_CELL_INIT 10'h140
`define OFS_GROUP_IRQ_ENABLE 10'h205
`define OFS_LINK_IRQ_ENABLE 10'h221

// Field positions
`define BIT_WATCH_CLOCK 7
`define BIT_RX_SM_RESET 5
`define BIT_INIT_DONE 7
`define BIT_INIT_START 0

// Reset values
`define RST_LINK_ENABLE 8'h00
`define RST_GROUP_ENABLE 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_TX_CELL_INIT 7'h00
`define RST_PHY_ADDR 5'h00

// Cycles taken to fill the filler and idle cell contents
`define TX_INIT_CYCLES 8'h40

`endif

/* File: core/utopia_rx_enable_pkg.sv */
// Types of the receive enable register bank
package utopia_rx_enable_pkg;

	typedef enum logic {
		INIT_IDLE,
		INIT_RUN
	} init_state_t;

	typedef struct packed {
		logic rx_clk_s1;
		logic rx_clk_s2;
		logic [4:0] addr_s1;
		logic [4:0] addr_s2;
		logic rx_clk_s3;
		logic [4:0] addr_cap;
		logic [7:0] link_en;
		logic [6:0] group_en;
		logic [3:0] group_irq_en;
		logic [7:0] link_irq_en;
		logic [6:0] tx_init;
		init_state_t init_state;
		logic [7:0] init_cnt;
		logic [3:0][4:0] link_addr;
		logic [3:0][4:0] group_addr;
		logic [7:0] rdata;
		logic rvalid;
		logic hit;
		logic hit_group;
		logic [1:0] hit_index;
		logic group_irq;
		logic link_irq;
	} bank_state_t;

endpackage

/* File: core/utopia_rx_enable_regs.sv */
// Receive cell bus port enable, interrupt enable and transmit cell memory init registers
//
// Overview of operation
// - Link enable register bits 3..0 enable each link's port address; reset zero.
// - Group enable register bits 3..0 enable each group's port address; reset zero.
// - Group enable bit 7 reads the live receive bus clock level.
// - Group enable bit 5 set holds receive bus state machines in reset.
// - Group overflow enable bits 3..0 gate group overflow interrupts; reset zero.
// - Link overflow enable bits 3..0 gate link overflow interrupts; reset zero.
// - Group overflow enable upper four bits read zero, ignore writes.
// - Init register bit 7 reads 0 while cell memory init runs, else 1.
// - Each link has its own 5-bit port address register, gated by its enable.
// - Each group has its own 5-bit port address register, gated by its enable.
`timescale 1ns/1ps
`include "utopia_rx_enable_cfg.svh"

module utopia_rx_enable_regs
	import utopia_rx_enable_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Processor port, same clock domain
	input wire logic cpu_cs,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [9:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	// Receive cell bus pins
	input wire logic rx_bus_clk,
	input wire logic [4:0] rx_bus_addr,
	// Overflow status from the receive FIFOs
	input wire logic [3:0] group_ovf_status,
	input wire logic [3:0] link_ovf_status,
	// Controls to the receive and transmit logic
	output logic [3:0] link_addr_enable,
	output logic [3:0] group_addr_enable,
	output logic rx_sm_reset,
	output logic [3:0] group_ovf_irq_enable,
	output logic [3:0] link_ovf_irq_enable,
	output logic group_ovf_irq,
	output logic link_ovf_irq,
	output logic tx_init_busy,
	// Port address match
	output logic addr_hit,
	output logic addr_hit_group,
	output logic [1:0] addr_hit_index
);

	////////////////////////////////////////////////////////////////////////////////
	bank_state_t st;
	bank_state_t next_st;
	logic wr_stb;
	logic rd_stb;

	assign wr_stb = cpu_cs & cpu_wr;
	assign rd_stb = cpu_cs & cpu_rd;

	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		// Pin sampling; the second stage feeds logic, and a third clock stage feeds the edge detect
		next_st.rx_clk_s1 = rx_bus_clk;
		next_st.rx_clk_s2 = st.rx_clk_s1;
		next_st.addr_s1 = rx_bus_addr;
		next_st.addr_s2 = st.addr_s1;
		next_st.rx_clk_s3 = st.rx_clk_s2;
		// Address pins move on the bus clock's rising edge; take the word at its falling
		// edge, when all five bits have settled, so no mixed word reaches the compare
		if (st.rx_clk_s3 && !st.rx_clk_s2) begin
			next_st.addr_cap = st.addr_s2;
		end

		// Initialization sequencer
		unique case (st.init_state)
			INIT_IDLE: begin
			end
			INIT_RUN: begin
				next_st.init_cnt = st.init_cnt - 8'h01;
				if (st.init_cnt == 8'h01) begin
					next_st.init_state = INIT_IDLE;
				end
			end
		endcase

		// Register writes
		if (wr_stb) begin
			if (cpu_addr == `OFS_LINK_ENABLE) begin
				next_st.link_en = cpu_wdata;
			end
			if (cpu_addr == `OFS_GROUP_ENABLE) begin
				next_st.group_en = cpu_wdata[6:0];
			end
			if (cpu_addr == `OFS_GROUP_IRQ_ENABLE) begin
				next_st.group_irq_en = cpu_wdata[3:0];
			end
			if (cpu_addr == `OFS_LINK_IRQ_ENABLE) begin
				next_st.link_irq_en = cpu_wdata;
			end
			if (cpu_addr == `OFS_TX_CELL_INIT) begin
				next_st.tx_init = cpu_wdata[6:0];
				// A new start while running restarts the fill from the top
				if (!cpu_wdata[`BIT_INIT_START]) begin
					next_st.init_state = INIT_RUN;
					next_st.init_cnt = `TX_INIT_CYCLES;
				end
			end
			for (int i = 0; i < 4; i++) begin
				if (cpu_addr == `OFS_LINK_ADDR_BASE + 10'(i)) begin
					next_st.link_addr[i] = cpu_wdata[4:0];
				end
				if (cpu_addr == `OFS_GROUP_ADDR_BASE + 10'(i)) begin
					next_st.group_addr[i] = cpu_wdata[4:0];
				end
			end
		end

		// Register reads; unmapped offsets answer zero
		if (rd_stb) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = 8'h00;
			if (cpu_addr == `OFS_LINK_ENABLE) begin
				next_st.rdata = st.link_en;
			end
			if (cpu_addr == `OFS_GROUP_ENABLE) begin
				next_st.rdata = {st.rx_clk_s2, st.group_en};
			end
			if (cpu_addr == `OFS_GROUP_IRQ_ENABLE) begin
				next_st.rdata = {4'h0, st.group_irq_en};
			end
			if (cpu_addr == `OFS_LINK_IRQ_ENABLE) begin
				next_st.rdata = st.link_irq_en;
			end
			if (cpu_addr == `OFS_TX_CELL_INIT) begin
				next_st.rdata = {st.init_state == INIT_IDLE, st.tx_init};
			end
			for (int i = 0; i < 4; i++) begin
				if (cpu_addr == `OFS_LINK_ADDR_BASE + 10'(i)) begin
					next_st.rdata = {3'h0, st.link_addr[i]};
				end
				if (cpu_addr == `OFS_GROUP_ADDR_BASE + 10'(i)) begin
					next_st.rdata = {3'h0, st.group_addr[i]};
				end
			end
		end

		// Interrupt gating per group and per link
		next_st.group_irq = |(group_ovf_status & st.group_irq_en);
		next_st.link_irq = |(link_ovf_status & st.link_irq_en[3:0]);

		// Address match: links win over groups, lower index first
		next_st.hit = 1'b0;
		next_st.hit_group = 1'b0;
		next_st.hit_index = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (st.group_en[i] && st.group_addr[i] == st.addr_cap) begin
				next_st.hit = 1'b1;
				next_st.hit_group = 1'b1;
				next_st.hit_index = 2'(i);
			end
		end
		for (int i = 3; i >= 0; i--) begin
			if (st.link_en[i] && st.link_addr[i] == st.addr_cap) begin
				next_st.hit = 1'b1;
				next_st.hit_group = 1'b0;
				next_st.hit_index = 2'(i);
			end
		end
		// Held reset clears the match so no poll is answered
		if (st.group_en[`BIT_RX_SM_RESET]) begin
			next_st.hit = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.link_en <= `RST_LINK_ENABLE;
			st.group_en <= 7'(`RST_GROUP_ENABLE);
			st.group_irq_en <= 4'(`RST_IRQ_ENABLE);
			st.link_irq_en <= `RST_IRQ_ENABLE;
			st.tx_init <= `RST_TX_CELL_INIT;
			st.init_state <= INIT_IDLE;
			st.link_addr <= {4{`RST_PHY_ADDR}};
			st.group_addr <= {4{`RST_PHY_ADDR}};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign cpu_rdata = st.rdata;
	assign cpu_rvalid = st.rvalid;
	assign link_addr_enable = st.link_en[3:0];
	assign group_addr_enable = st.group_en[3:0];
	assign rx_sm_reset = st.group_en[`BIT_RX_SM_RESET];
	assign group_ovf_irq_enable = st.group_irq_en;
	assign link_ovf_irq_enable = st.link_irq_en[3:0];
	assign group_ovf_irq = st.group_irq;
	assign link_ovf_irq = st.link_irq;
	assign tx_init_busy = (st.init_state == INIT_RUN);
	assign addr_hit = st.hit;
	assign addr_hit_group = st.hit_group;
	assign addr_hit_index = st.hit_index;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_link_en_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_stb && cpu_addr == `OFS_LINK_ENABLE |=> link_addr_enable == $past(cpu_wdata[3:0]))
		else $error("link enable not written");
	a_group_en_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_stb && cpu_addr == `OFS_GROUP_ENABLE |=> group_addr_enable == $past(cpu_wdata[3:0]))
		else $error("group enable not written");
	a_watch_clock_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_stb && cpu_addr == `OFS_GROUP_ENABLE |=> cpu_rvalid && cpu_rdata[7] == $past(st.rx_clk_s2))
		else $error("watch clock bit wrong");
	a_rx_reset_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rx_sm_reset |=> !addr_hit)
		else $error("match answered during held reset");
	a_group_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		##1 group_ovf_irq == |($past(group_ovf_status) & $past(group_ovf_irq_enable)))
		else $error("group interrupt gating wrong");
	a_link_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		##1 link_ovf_irq == |($past(link_ovf_status) & $past(link_ovf_irq_enable)))
		else $error("link interrupt gating wrong");
	a_group_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_stb && cpu_addr == `OFS_GROUP_IRQ_ENABLE |=> cpu_rdata[7:4] == 4'h0)
		else $error("group irq enable upper bits not zero");
	a_init_runs: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_stb && cpu_addr == `OFS_TX_CELL_INIT && !cpu_wdata[0] |=> tx_init_busy [*8])
		else $error("init did not start");
	a_init_ends: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_stb && cpu_addr == `OFS_TX_CELL_INIT && !cpu_wdata[0] |->
		##[1:65] (!tx_init_busy || (wr_stb && cpu_addr == `OFS_TX_CELL_INIT && !cpu_wdata[0])))
		else $error("init did not complete");
	a_init_flag_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_stb && cpu_addr == `OFS_TX_CELL_INIT |=> cpu_rdata[7] == !$past(tx_init_busy))
		else $error("init flag read wrong");
	a_hit_enabled: assert property (@(posedge ref_clk) disable iff (!rst_b)
		addr_hit |-> ((((addr_hit_group ? $past(group_addr_enable) : $past(link_addr_enable)) >>
		addr_hit_index) & 4'h1) == 4'h1))
		else $error("match on disabled address");

	c_init_done: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(tx_init_busy));
	c_link_hit: cover property (@(posedge ref_clk) disable iff (!rst_b) addr_hit && !addr_hit_group);
	c_group_hit: cover property (@(posedge ref_clk) disable iff (!rst_b) addr_hit && addr_hit_group);
	c_clock_high: cover property (@(posedge ref_clk) disable iff (!rst_b) cpu_rvalid && cpu_rdata[7]);

endmodule

/* File: testbench/rx_bus_master.sv */
// Behavioural receive bus master that clocks the bus and drives the port address pins
`timescale 1ns/1ps

module rx_bus_master (
	// Control from the bench
	input wire logic [4:0] addr_req,
	// Bus pins
	output logic rx_bus_clk,
	output logic [4:0] rx_bus_addr
);
	initial begin
		rx_bus_clk = 1'b0;
		rx_bus_addr = 5'h1f;
	end
	// Runs free for the whole run, so every register access sees a toggling bus clock
	always begin
		#40;
		rx_bus_clk = ~rx_bus_clk;
	end
	// Address launched on the rising edge, so it is never sampled mid-change by the register bank
	always @(posedge rx_bus_clk) rx_bus_addr <= addr_req;
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the receive enable register bank
`timescale 1ns/1ps
`include "utopia_rx_enable_cfg.svh"

module testbench;
	logic ref_clk = 1'b0, rst_b = 1'b0, cpu_cs = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
	logic [9:0] cpu_addr = 10'h000;
	logic [7:0] cpu_wdata = 8'h00;
	logic [3:0] group_ovf_status = 4'h0, link_ovf_status = 4'h0;
	logic [2:0] pin_hist = 3'h0;
	logic [4:0] addr_req = 5'h1f;
	logic [7:0] cpu_rdata, rv;
	logic cpu_rvalid, rx_bus_clk, rx_sm_reset, group_ovf_irq, link_ovf_irq, tx_init_busy;
	logic addr_hit, addr_hit_group;
	logic [1:0] addr_hit_index;
	logic [3:0] link_addr_enable, group_addr_enable, group_ovf_irq_enable, link_ovf_irq_enable;
	logic [4:0] rx_bus_addr;
	logic [4:0] laddr [4], gaddr [4];
	logic [3:0] len_b = 4'b0101, gen_b = 4'b1110;
	logic [31:0] seed = 32'h721a;
	int failures = 0, checked = 0, n;

	utopia_rx_enable_regs i_utopia_rx_enable_regs (.ref_clk, .rst_b, .cpu_cs, .cpu_wr,
		.cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .rx_bus_clk, .rx_bus_addr,
		.group_ovf_status, .link_ovf_status, .link_addr_enable, .group_addr_enable,
		.rx_sm_reset, .group_ovf_irq_enable, .link_ovf_irq_enable, .group_ovf_irq,
		.link_ovf_irq, .tx_init_busy, .addr_hit, .addr_hit_group, .addr_hit_index);
	rx_bus_master i_rx_bus_master (.addr_req, .rx_bus_clk, .rx_bus_addr);

	always #2.5 ref_clk = ~ref_clk;
	// Bus clock level two clock edges back, which is what the watch bit shows
	always @(posedge ref_clk) pin_hist <= {pin_hist[1:0], rx_bus_clk};

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Links win over groups, lower index first
	function automatic logic [3:0] exp_hit(input logic [4:0] a);
		for (int i = 0; i < 4; i++) if (len_b[i] && laddr[i] === a) return {2'b10, 2'(i)};
		for (int i = 0; i < 4; i++) if (gen_b[i] && gaddr[i] === a) return {2'b11, 2'(i)};
		return 4'h0;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk) #1;
		{cpu_cs, cpu_wr, cpu_addr, cpu_wdata} = {2'b11, a, d};
		@(posedge ref_clk) #1;
		{cpu_cs, cpu_wr} = 2'b00;
	endtask
	task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
		@(posedge ref_clk) #1;
		{cpu_cs, cpu_rd, cpu_addr} = {2'b11, a};
		@(posedge ref_clk) #1;
		{cpu_cs, cpu_rd} = 2'b00;
		if (a == `OFS_GROUP_ENABLE) exp[7] = pin_hist[2];
		chk({7'h00, cpu_rvalid}, 8'h01);
		chk(cpu_rdata, exp);
	endtask
	// Slack covers one bus clock for launch plus the synchroniser
	task automatic wait_hit(input logic [4:0] a);
		logic [3:0] e;
		e = exp_hit(a);
		addr_req = a;
		repeat (40) @(posedge ref_clk);
		#1;
		chk({4'h0, addr_hit, e[3] ? {addr_hit_group, addr_hit_index} : 3'h0}, {4'h0, e});
	endtask
	task automatic count_init();
		for (n = 0; n < 200 && tx_init_busy !== 1'b0; n++) @(posedge ref_clk) #1;
		chk(8'(n), `TX_INIT_CYCLES);
	endtask
	task automatic finish_test();
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		rd_reg(`OFS_LINK_ENABLE, 8'h00);
		rd_reg(`OFS_GROUP_ENABLE, 8'h00);
		rd_reg(`OFS_GROUP_IRQ_ENABLE, 8'h00);
		rd_reg(`OFS_LINK_IRQ_ENABLE, 8'h00);
		rd_reg(`OFS_TX_CELL_INIT, 8'h80);
		rd_reg(10'h3ff, 8'h00);
		// Reads spread over more than two bus clock periods see both levels
		for (int k = 0; k < 8; k++) begin
			repeat (3) @(posedge ref_clk);
			rd_reg(`OFS_GROUP_ENABLE, 8'h00);
		end
		for (int k = 0; k < 8; k++) begin
			rv = {4'h0, 4'(xs())};
			wr_reg(`OFS_LINK_IRQ_ENABLE, rv);
			wr_reg(`OFS_GROUP_IRQ_ENABLE, ~rv);
			rd_reg(`OFS_LINK_IRQ_ENABLE, rv);
			rd_reg(`OFS_GROUP_IRQ_ENABLE, {4'h0, ~rv[3:0]});
			group_ovf_status = 4'(xs());
			link_ovf_status = 4'(xs());
			@(posedge ref_clk) #1;
			chk({group_ovf_irq_enable, link_ovf_irq_enable}, {~rv[3:0], rv[3:0]});
			chk({6'h0, group_ovf_irq, link_ovf_irq}, {6'h0, |(group_ovf_status & ~rv[3:0]),
				|(link_ovf_status & rv[3:0])});
		end
		for (int k = 0; k < 4; k++) begin
			laddr[k] = 5'(xs());
			gaddr[k] = (k == 3) ? laddr[0] : 5'(xs());
			wr_reg(`OFS_LINK_ADDR_BASE + 10'(k), {3'h0, laddr[k]});
			wr_reg(`OFS_GROUP_ADDR_BASE + 10'(k), {3'h0, gaddr[k]});
			rd_reg(`OFS_GROUP_ADDR_BASE + 10'(k), {3'h0, gaddr[k]});
			rd_reg(`OFS_LINK_ADDR_BASE + 10'(k), {3'h0, laddr[k]});
		end
		wr_reg(`OFS_LINK_ENABLE, {4'h0, len_b});
		wr_reg(`OFS_GROUP_ENABLE, {4'h0, gen_b});
		chk({link_addr_enable, group_addr_enable}, {len_b, gen_b});
		for (int k = 0; k < 4; k++) begin
			wait_hit(laddr[k]);
			wait_hit(gaddr[k]);
		end
		wait_hit(5'(xs()));
		wr_reg(`OFS_GROUP_ENABLE, {4'h2, gen_b});
		chk({7'h0, rx_sm_reset}, 8'h01);
		addr_req = laddr[0];
		repeat (40) @(posedge ref_clk);
		#1;
		chk({7'h0, addr_hit}, 8'h00);
		wr_reg(`OFS_GROUP_ENABLE, {4'h0, gen_b});
		chk({7'h0, rx_sm_reset}, 8'h00);
		wait_hit(laddr[0]);
		wr_reg(`OFS_TX_CELL_INIT, 8'h01);
		chk({7'h0, tx_init_busy}, 8'h00);
		rd_reg(`OFS_TX_CELL_INIT, 8'h81);
		wr_reg(`OFS_TX_CELL_INIT, 8'h00);
		rd_reg(`OFS_TX_CELL_INIT, 8'h00);
		wr_reg(`OFS_TX_CELL_INIT, 8'h00);
		count_init();
		rd_reg(`OFS_TX_CELL_INIT, 8'h80);
		finish_test();
	end
endmodule
